// file: rtl/scl_pkg.sv
// Purpose: Constants for the synthesizer configuration latch bank
// Assumes: 24-bit serial words, latch select in the two lowest bits
// Notes: Field positions of the control, feedback and reference latches
package scl_pkg;
    localparam int WORD_W = 24;
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_REFERENCE = 2'h1;
    localparam logic [1:0] SEL_FEEDBACK = 2'h2;
    localparam logic [1:0] SEL_TEST = 2'h3;
    // Control latch fields
    localparam int CTL_CORE_LVL = 2;
    localparam int CTL_DIV_RESET = 4;
    localparam int CTL_MUX_SEL = 5;
    localparam int CTL_POLARITY = 8;
    localparam int CTL_TRISTATE = 9;
    localparam int CTL_GAIN = 10;
    localparam int CTL_MUTE = 11;
    localparam int CTL_OUT_LVL = 12;
    localparam int CTL_CUR_A = 14;
    localparam int CTL_CUR_B = 17;
    localparam int CTL_PD_REQ = 20;
    localparam int CTL_PD_SYNC = 21;
    // Feedback latch fields
    localparam int FB_RATIO_LSB = 8;
    localparam int FB_RATIO_W = 13;
    localparam int FB_GAIN = 21;
    // Reference latch fields
    localparam int REF_RATIO_LSB = 2;
    localparam int REF_RATIO_W = 14;
    localparam int REF_BACKLASH = 16;
    localparam int REF_PRECISION = 18;
    localparam int REF_TEST = 19;
    localparam int REF_BAND_DIV = 20;
    // Reset values
    localparam logic [23:0] CONTROL_RESET = 24'h000000;
    localparam logic [23:0] FEEDBACK_RESET = 24'h000300;
    localparam logic [23:0] REFERENCE_RESET = 24'h000004;
    // Lock detect cycle counts and windows
    localparam logic [2:0] LOCK_CYCLES_FINE = 3'h5;
    localparam logic [2:0] LOCK_CYCLES_COARSE = 3'h3;
    localparam int LOCK_WINDOW_NS = 15;
    localparam int UNLOCK_WINDOW_NS = 25;
    localparam int CLK_PERIOD_NS = 10;
    // Lock window rounds down to at least one cycle, unlock window rounds up
    localparam int LOCK_WINDOW_CYC = (LOCK_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 : (LOCK_WINDOW_NS / CLK_PERIOD_NS);
    localparam int UNLOCK_WINDOW_CYC = (UNLOCK_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_PD_EDGES = 2;
endpackage

// file: rtl/scl_shift_if.sv
// Purpose: Carries a completed serial word from the shifter to the latches
// Assumes: One clock domain
// Notes: strobe is a one-cycle pulse
`timescale 1ns/1ps
interface scl_shift_if;
    logic [23:0] word;
    logic strobe;
    modport src (output word, output strobe);
    modport dst (input word, input strobe);
endinterface

// file: rtl/scl_shifter.sv
// Purpose: Serial input register for the latch bank
// Assumes: Pins already synchronised to clk
// Notes: Keeps shifting during power-down
`timescale 1ns/1ps
module scl_shifter
    import scl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk_s,
    input wire logic sdata_s,
    input wire logic strobe_s,
    scl_shift_if.src out
);
    logic sclk_d;
    logic strobe_d;
    logic [23:0] shreg;

    // =====================
    // Shift register, MSB first on serial clock rise
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_d <= 1'b0;
            shreg <= 24'h000000;
        end
        else
        begin
            sclk_d <= sclk_s;
            if (sclk_s && !sclk_d)
                shreg <= {shreg[22:0], sdata_s};
        end
    end

    // =====================
    // Latch strobe rise transfers the word
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobe_d <= 1'b0;
            out.strobe <= 1'b0;
            out.word <= 24'h000000;
        end
        else
        begin
            strobe_d <= strobe_s;
            out.strobe <= strobe_s && !strobe_d;
            if (strobe_s && !strobe_d)
                out.word <= shreg;
        end
    end

    AST_STROBE_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        out.strobe |=> !out.strobe) else $error("latch strobe pulse too long");
endmodule

// file: rtl/scl_latch_bank.sv
// Purpose: Configuration latch bank of an integer-N synthesizer
// Assumes: clk 100 MHz; serial pins, chip enable and loop events are asynchronous
// Notes: Analog sections are represented by their control outputs only
`timescale 1ns/1ps
// Summary of operation
// - Host shifts 24 bits MSB first; strobe rise copies word to selected latch.
// - Select bits 00 route the word to the control latch.
// - Feedback latch bits 20..8 hold the divide ratio, valid 3 to 8191.
// - Pump gain holds the latest value written via either latch.
// - Gain 1 uses the second current setting, 0 the first.
// - First setting from low current bits, second from high current bits.
// - Request 1 with sync 0 powers down immediately.
// - Both 1 powers down on second reference edge after strobe rise.
// - Chip enable low disables the device at once.
// - Power-down loads counters, tristates pump, resets lock, disables outputs.
// - Serial register keeps working during power-down.
// - Mute-until-locked keeps RF outputs off until lock.
// - Tristate bit 1 puts the pump output in high impedance.
// - Polarity bit 1 positive, 0 negative.
// - Divider reset bit holds reference and feedback counters in reset.
// - Select 01 loads reference latch; bits 15..2 ratio, 1 to 16383.
// - Reference bits 16 and 17 set antibacklash width.
// - Lock after five fine cycles if precision 1, three if 0.
// - Lock holds until a cycle shows more than 25 ns error.
// - Test bit written 0; test latch contents are then ignored.
// - Band clock bits enable a divider of the reference output.
// - Band divider divides by 1, 2, 4 or 8.
module scl_latch_bank
    import scl_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic latch_strobe,
    input wire logic chip_enable,
    input wire logic reference_edge,
    input wire logic phase_error_flag,
    output logic [FB_RATIO_W-1:0] feedback_ratio,
    output logic [REF_RATIO_W-1:0] reference_ratio,
    output logic [2:0] pump_current_sel,
    output logic pump_tristate,
    output logic detector_polarity_bit,
    output logic counters_held,
    output logic [1:0] antibacklash_width,
    output logic [1:0] core_power_level,
    output logic [1:0] output_power_level,
    output logic [2:0] output_select,
    output logic rf_output_enable,
    output logic reference_buffer_enable,
    output logic powered_down,
    output logic lock_detect,
    output logic band_select_clock_en
);
    logic rst_s1;
    logic rst_n_i;
    logic [1:0] sck_sync;
    logic [1:0] sdat_sync;
    logic [1:0] le_sync;
    logic [1:0] ce_sync;
    logic [1:0] ref_sync;
    logic [1:0] err_sync;
    logic ref_d;
    logic ref_rise;
    logic [23:0] control_word;
    logic [23:0] feedback_word;
    logic [23:0] reference_word;
    logic pump_gain_select;
    logic sync_pending;
    logic [1:0] sync_edges;
    logic pd_state;
    logic next_pd;
    logic [2:0] good_cycles;
    logic [2:0] lock_target;
    logic [7:0] err_len;
    logic err_d;
    logic [2:0] band_cnt;
    logic [2:0] band_mask;
    logic [1:0] band_div_sel;
    scl_shift_if sif ();

    // ==========================================
    // Reset release and pin synchronisers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_s1 <= 1'b0;
            rst_n_i <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n_i <= rst_s1;
        end
    end

    always_ff @(posedge clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sck_sync <= 2'h0;
            sdat_sync <= 2'h0;
            le_sync <= 2'h0;
            ce_sync <= 2'h3;
            ref_sync <= 2'h0;
            err_sync <= 2'h0;
        end
        else
        begin
            sck_sync <= {sck_sync[0], serial_clock};
            sdat_sync <= {sdat_sync[0], serial_data};
            le_sync <= {le_sync[0], latch_strobe};
            ce_sync <= {ce_sync[0], chip_enable};
            ref_sync <= {ref_sync[0], reference_edge};
            err_sync <= {err_sync[0], phase_error_flag};
        end
    end

    always_ff @(posedge clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ref_d <= 1'b0;
        else
            ref_d <= ref_sync[1];
    end
    assign ref_rise = ref_sync[1] && !ref_d;

    // ==========================================
    // Serial input register
    scl_shifter u_shifter (
        .clk(clk),
        .rst_n(rst_n_i),
        .sclk_s(sck_sync[1]),
        .sdata_s(sdat_sync[1]),
        .strobe_s(le_sync[1]),
        .out(sif.src)
    );

    // ==========================================
    // Latch decode
    always_ff @(posedge clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            control_word <= CONTROL_RESET;
            feedback_word <= FEEDBACK_RESET;
            reference_word <= REFERENCE_RESET;
        end
        else if (sif.strobe)
        begin
            case (sif.word[1:0])
                SEL_CONTROL: control_word <= sif.word;
                SEL_REFERENCE: reference_word <= sif.word;
                SEL_FEEDBACK: feedback_word <= sif.word;
                default: ;
            endcase
        end
    end

    // Shared gain bit follows the latest write from either latch
    always_ff @(posedge clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pump_gain_select <= 1'b0;
        else if (sif.strobe && sif.word[1:0] == SEL_CONTROL)
            pump_gain_select <= sif.word[CTL_GAIN];
        else if (sif.strobe && sif.word[1:0] == SEL_FEEDBACK)
            pump_gain_select <= sif.word[FB_GAIN];
    end

    // ==========================================
    // Power-down sequencing
    always_ff @(posedge clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync_pending <= 1'b0;
            sync_edges <= 2'h0;
        end
        else if (sif.strobe)
        begin
            sync_pending <= sif.word[1:0] == SEL_CONTROL && sif.word[CTL_PD_REQ] && sif.word[CTL_PD_SYNC];
            sync_edges <= 2'h0;
        end
        else if (sync_pending && ref_rise)
        begin
            sync_edges <= sync_edges + 2'h1;
            if (sync_edges == 2'(SYNC_PD_EDGES - 1))
                sync_pending <= 1'b0;
        end
    end

    always_comb
    begin
        next_pd = pd_state;
        if (!control_word[CTL_PD_REQ])
            next_pd = 1'b0;
        else if (!control_word[CTL_PD_SYNC])
            next_pd = 1'b1;
        else if (sync_pending && ref_rise && sync_edges == 2'(SYNC_PD_EDGES - 1))
            next_pd = 1'b1;
        if (!ce_sync[1])
            next_pd = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pd_state <= 1'b0;
        else
            pd_state <= next_pd;
    end

    // ==========================================
    // Lock detection
    assign lock_target = reference_word[REF_PRECISION] ? LOCK_CYCLES_FINE : LOCK_CYCLES_COARSE;

    always_ff @(posedge clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            err_len <= 8'h00;
            err_d <= 1'b0;
            good_cycles <= 3'h0;
            lock_detect <= 1'b0;
        end
        else if (pd_state || control_word[CTL_DIV_RESET])
        begin
            err_len <= 8'h00;
            err_d <= 1'b0;
            good_cycles <= 3'h0;
            lock_detect <= 1'b0;
        end
        else
        begin
            err_d <= err_sync[1];
            if (err_sync[1])
            begin
                if (err_len != 8'hFF)
                    err_len <= err_len + 8'h01;
            end
            else
                err_len <= 8'h00;
            if (!err_sync[1] && err_d)
            begin
                if (err_len < 8'(LOCK_WINDOW_CYC) + 8'h01)
                begin
                    if (good_cycles != lock_target)
                        good_cycles <= good_cycles + 3'h1;
                    if (good_cycles + 3'h1 >= lock_target)
                        lock_detect <= 1'b1;
                end
                else
                    good_cycles <= 3'h0;
            end
            if (err_sync[1] && err_len >= 8'(UNLOCK_WINDOW_CYC))
            begin
                lock_detect <= 1'b0;
                good_cycles <= 3'h0;
            end
        end
    end

    // ==========================================
    // Band select clock divider
    assign band_div_sel = reference_word[REF_BAND_DIV +: 2];
    assign band_mask = 3'((4'h1 << band_div_sel) - 4'h1);

    always_ff @(posedge clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            band_cnt <= 3'h0;
            band_select_clock_en <= 1'b0;
        end
        else if (pd_state || control_word[CTL_DIV_RESET])
        begin
            band_cnt <= 3'h0;
            band_select_clock_en <= 1'b0;
        end
        else
        begin
            band_select_clock_en <= ref_rise && ((band_cnt & band_mask) == 3'h0);
            if (ref_rise)
                band_cnt <= band_cnt + 3'h1;
        end
    end

    // ==========================================
    // Registered control outputs
    always_ff @(posedge clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            feedback_ratio <= '0;
            reference_ratio <= '0;
            pump_current_sel <= 3'h0;
            pump_tristate <= 1'b1;
            detector_polarity_bit <= 1'b0;
            counters_held <= 1'b1;
            antibacklash_width <= 2'h0;
            core_power_level <= 2'h0;
            output_power_level <= 2'h0;
            output_select <= 3'h0;
            rf_output_enable <= 1'b0;
            reference_buffer_enable <= 1'b0;
            powered_down <= 1'b0;
        end
        else
        begin
            feedback_ratio <= feedback_word[FB_RATIO_LSB +: FB_RATIO_W];
            reference_ratio <= reference_word[REF_RATIO_LSB +: REF_RATIO_W];
            pump_current_sel <= pump_gain_select ? control_word[CTL_CUR_B +: 3]
                : control_word[CTL_CUR_A +: 3];
            pump_tristate <= control_word[CTL_TRISTATE] || next_pd;
            detector_polarity_bit <= control_word[CTL_POLARITY];
            counters_held <= control_word[CTL_DIV_RESET] || next_pd;
            antibacklash_width <= reference_word[REF_BACKLASH +: 2];
            core_power_level <= control_word[CTL_CORE_LVL +: 2];
            output_power_level <= control_word[CTL_OUT_LVL +: 2];
            output_select <= control_word[CTL_MUX_SEL +: 3];
            rf_output_enable <= !next_pd && (!control_word[CTL_MUTE] || lock_detect);
            reference_buffer_enable <= !next_pd;
            powered_down <= next_pd;
        end
    end

    // ==========================================
    // Checks
    AST_CE_DISABLE: assert property (@(posedge clk) disable iff (!rst_n_i)
        !ce_sync[1] |=> powered_down && !rf_output_enable) else $error("chip enable low not disabling");
    AST_PD_TRISTATE: assert property (@(posedge clk) disable iff (!rst_n_i)
        powered_down |-> pump_tristate && counters_held && !reference_buffer_enable) else $error("power-down incomplete");
    AST_MUTE: assert property (@(posedge clk) disable iff (!rst_n_i)
        (control_word[CTL_MUTE] && !lock_detect) |=> !rf_output_enable) else $error("RF on before lock");
    AST_GAIN_FB: assert property (@(posedge clk) disable iff (!rst_n_i)
        (sif.strobe && sif.word[1:0] == SEL_FEEDBACK) |=> pump_gain_select == $past(sif.word[FB_GAIN])) else $error("gain not from feedback write");
    AST_CURRENT: assert property (@(posedge clk) disable iff (!rst_n_i)
        pump_gain_select |=> pump_current_sel == $past(control_word[CTL_CUR_B +: 3])) else $error("wrong current setting");
    AST_ASYNC_PD: assert property (@(posedge clk) disable iff (!rst_n_i)
        (control_word[CTL_PD_REQ] && !control_word[CTL_PD_SYNC]) |=> powered_down) else $error("async power-down late");
    AST_TEST_IGNORED: assert property (@(posedge clk) disable iff (!rst_n_i)
        (sif.strobe && sif.word[1:0] == SEL_TEST) |=> $stable(control_word) && $stable(reference_word) && $stable(feedback_word)) else $error("test latch altered state");
    AST_LOCK_DROP: assert property (@(posedge clk) disable iff (!rst_n_i)
        (err_sync[1] && err_len >= 8'(UNLOCK_WINDOW_CYC) && !pd_state) |=> !lock_detect) else $error("lock held over large error");
    AST_DIV_RESET: assert property (@(posedge clk) disable iff (!rst_n_i)
        control_word[CTL_DIV_RESET] |=> counters_held) else $error("counters not held");
endmodule

// file: verification/scl_host_model.sv
// Purpose: Host side of the three-wire serial interface
// Assumes: Serial clock high and low for 4 clk each
// Notes: Serial clock stands low and data shows the inverse bit between frames
`timescale 1ns/1ps
module scl_host_model
(
    input wire logic clk,
    output logic serial_clock,
    output logic serial_data,
    output logic latch_strobe
);
    // ========================================
    // Idle levels
    initial
    begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        latch_strobe = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ========================================
    // Word transfer
    task automatic write_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--)
        begin
            serial_data = w[i];
            hold(2);
            serial_clock = 1'b1;
            hold(4);
            serial_clock = 1'b0;
            hold(2);
        end
        serial_data = ~w[0];
        latch_strobe = 1'b1;
        hold(4);
        latch_strobe = 1'b0;
        hold(6);
    endtask
endmodule

// file: verification/scl_latch_bank_bench.sv
// Purpose: Self-checking bench for the configuration latch bank
// Assumes: 100 MHz clock, host model drives the serial pins
// Notes: Reference and phase error pins are driven by the bench
`timescale 1ns/1ps
module scl_latch_bank_bench;
    import scl_pkg::*;
    logic clk, reset_n, chip_enable, reference_edge, phase_error_flag;
    logic serial_clock, serial_data, latch_strobe;
    logic [12:0] feedback_ratio;
    logic [13:0] reference_ratio;
    logic [2:0] pump_current_sel, output_select;
    logic pump_tristate, detector_polarity_bit, counters_held;
    logic [1:0] antibacklash_width, core_power_level, output_power_level;
    logic rf_output_enable, reference_buffer_enable, powered_down, lock_detect, band_select_clock_en;
    int miscompares = 0;
    int compares = 0;
    int band_count = 0;
    logic [23:0] cw;

    scl_host_model u_host (.clk(clk), .serial_clock(serial_clock), .serial_data(serial_data),
        .latch_strobe(latch_strobe));
    scl_latch_bank u_dut (.clk(clk), .reset_n(reset_n), .serial_clock(serial_clock),
        .serial_data(serial_data), .latch_strobe(latch_strobe), .chip_enable(chip_enable),
        .reference_edge(reference_edge), .phase_error_flag(phase_error_flag),
        .feedback_ratio(feedback_ratio), .reference_ratio(reference_ratio),
        .pump_current_sel(pump_current_sel), .pump_tristate(pump_tristate),
        .detector_polarity_bit(detector_polarity_bit), .counters_held(counters_held),
        .antibacklash_width(antibacklash_width), .core_power_level(core_power_level),
        .output_power_level(output_power_level), .output_select(output_select),
        .rf_output_enable(rf_output_enable), .reference_buffer_enable(reference_buffer_enable),
        .powered_down(powered_down), .lock_detect(lock_detect),
        .band_select_clock_en(band_select_clock_en));

    // ========================================
    // Clock, pulse counter and helpers
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
        if (band_select_clock_en === 1'b1)
            band_count++;

    function automatic logic [23:0] fld(input int v, input int pos);
        return 24'(v) << pos;
    endfunction

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One reference cycle; the error flag is high for err clk at its start
    task automatic ref_pulse(input int err);
        reference_edge = 1'b1;
        phase_error_flag = (err > 0);
        for (int i = 0; i < 8; i++)
        begin
            wait_clk(1);
            if (i == err - 1)
                phase_error_flag = 1'b0;
            if (i == 3)
                reference_edge = 1'b0;
        end
    endtask

    task automatic close_out();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ========================================
    // Scenarios
    task automatic t_power_up();
        chk(feedback_ratio, 16'h0003);
        chk(reference_ratio, 16'h0001);
        chk(powered_down, 16'h0000);
        u_host.write_word(fld(16383, 2) | fld(2, 16) | SEL_REFERENCE);
        chk(reference_ratio, 16'h3FFF);
        chk(antibacklash_width, 16'h0002);
        u_host.write_word(cw);
        chk(core_power_level, 16'h0001);
        chk(pump_current_sel, 16'h0002);
        u_host.write_word(fld(8191, 8) | fld(1, 21) | SEL_FEEDBACK);
        chk(feedback_ratio, 16'h1FFF);
        chk(pump_current_sel, 16'h0005);
    endtask

    task automatic t_gain_paths();
        u_host.write_word(cw);
        chk(pump_current_sel, 16'h0002);
        u_host.write_word(fld(3, 8) | fld(1, FB_GAIN) | SEL_FEEDBACK);
        chk(feedback_ratio, 16'h0003);
        chk(pump_current_sel, 16'h0005);
        u_host.write_word(cw | fld(3, 22));
        chk(powered_down, 16'h0000);
        chk(pump_current_sel, 16'h0002);
        u_host.write_word(cw | fld(1, CTL_GAIN));
        chk(pump_current_sel, 16'h0005);
        u_host.write_word(fld(3, 8) | SEL_FEEDBACK);
        chk(pump_current_sel, 16'h0002);
        chk(feedback_ratio, 16'h0003);
    endtask

    task automatic t_fields_and_test_latch();
        u_host.write_word(cw | fld(1, CTL_TRISTATE) | fld(1, CTL_POLARITY) | fld(1, CTL_DIV_RESET)
            | fld(3, CTL_OUT_LVL) | fld(5, CTL_MUX_SEL));
        chk(pump_tristate, 16'h0001);
        chk(detector_polarity_bit, 16'h0001);
        chk(counters_held, 16'h0001);
        chk({output_power_level, 1'b0, output_select}, 16'h0035);
        u_host.write_word(cw);
        chk({pump_tristate, detector_polarity_bit, counters_held}, 16'h0000);
        u_host.write_word(24'hFFFFFF);
        chk(reference_ratio, 16'h3FFF);
        chk(pump_current_sel, 16'h0002);
    endtask

    task automatic t_async_power_down();
        u_host.write_word(cw | fld(1, CTL_PD_REQ));
        chk(powered_down, 16'h0001);
        chk({pump_tristate, counters_held, rf_output_enable, reference_buffer_enable}, 16'h000C);
        u_host.write_word(fld(5, 2) | SEL_REFERENCE);
        chk(reference_ratio, 16'h0005);
        u_host.write_word(cw);
        chk(powered_down, 16'h0000);
    endtask

    task automatic t_sync_power_down();
        u_host.write_word(cw | fld(1, CTL_PD_REQ) | fld(1, CTL_PD_SYNC));
        chk(powered_down, 16'h0000);
        ref_pulse(0);
        chk(powered_down, 16'h0000);
        ref_pulse(0);
        chk(powered_down, 16'h0001);
        chk(lock_detect, 16'h0000);
        u_host.write_word(cw);
        chip_enable = 1'b0;
        wait_clk(4);
        chk({powered_down, rf_output_enable}, 16'h0002);
        chip_enable = 1'b1;
        wait_clk(4);
        chk(powered_down, 16'h0000);
    endtask

    task automatic t_lock_and_mute();
        u_host.write_word(cw | fld(1, CTL_MUTE));
        chk(rf_output_enable, 16'h0000);
        for (int i = 0; i < 3; i++)
            ref_pulse(1);
        chk(lock_detect, 16'h0001);
        chk(rf_output_enable, 16'h0001);
        ref_pulse(1);
        chk(lock_detect, 16'h0001);
        ref_pulse(5);
        chk(lock_detect, 16'h0000);
        u_host.write_word(fld(5, 2) | fld(1, REF_PRECISION) | SEL_REFERENCE);
        for (int i = 0; i < 4; i++)
            ref_pulse(1);
        chk(lock_detect, 16'h0000);
        ref_pulse(1);
        chk(lock_detect, 16'h0001);
    endtask

    task automatic t_band_divider();
        for (int code = 0; code < 4; code++)
        begin
            u_host.write_word(fld(5, 2) | fld(code, REF_BAND_DIV) | SEL_REFERENCE);
            band_count = 0;
            for (int i = 0; i < 8; i++)
                ref_pulse(0);
            chk(16'(band_count), 16'(8 >> code));
        end
    endtask

    // ========================================
    // Main sequence and watchdog
    initial
    begin
        reset_n = 1'b0;
        chip_enable = 1'b1;
        reference_edge = 1'b0;
        phase_error_flag = 1'b0;
        cw = fld(1, CTL_CORE_LVL) | fld(2, CTL_CUR_A) | fld(5, CTL_CUR_B) | SEL_CONTROL;
        wait_clk(5);
        reset_n = 1'b1;
        wait_clk(4);
        t_power_up();
        t_gain_paths();
        t_fields_and_test_latch();
        t_async_power_down();
        t_sync_power_down();
        t_lock_and_mute();
        t_band_divider();
        close_out();
    end

    initial
    begin
        #200000;
        miscompares++;
        close_out();
    end
endmodule
